// File: src/jtag_tap_and_debug_gate.sv
// test access port with instruction and data register paths, debug gating and breakpoint unit
// assumes tck, tms, tdi come from an external test controller; fuses and lock bits are static levels
`timescale 1ns/1ps
module jtag_tap_and_debug_gate
    import jtag_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoOe,
    input wire logic testPortEnableFuse,
    input wire logic debugEnableFuse,
    input wire logic lockBitOne,
    input wire logic lockBitTwo,
    output logic pinsAsPort,
    output logic debugActive,
    output logic [3:0] instruction,
    input wire logic cpuDataWrite,
    input wire logic [7:0] cpuData,
    output logic commDirty,
    output logic [7:0] commByte,
    output logic injectValid,
    output logic [15:0] injectWord,
    input wire logic [15:0] pcAddr,
    input wire logic pcValid,
    input wire logic [15:0] dataAddr,
    input wire logic dataValid,
    input wire logic flowChange,
    input wire logic stepDone,
    output logic breakHit
);
    // ============================================================
    // tck domain declarations
    logic tckRst_n;
    tap_if tapBus();
    logic [IR_W-1:0] irShift;
    logic [IR_W-1:0] irLatched;
    logic [DR_MAX_W-1:0] drShift;
    logic [DR_MAX_W-1:0] next_drShift;
    logic [DR_MAX_W-1:0] bpCfgTck;
    logic [15:0] injWordTck;
    dr_sel_t drSel;
    logic [6:0] drWidth;
    logic irTog;
    logic bpTog;
    logic injTog;
    logic clrTog;
    logic dbgTckS1;
    logic dbgTckS2;
    logic dirtyTckS1;
    logic dirtyTckS2;

    // an unprogrammed port fuse holds the whole tck side in reset; tms and tdi are then ignored
    assign tckRst_n = reset_n & testPortEnableFuse;
    assign tapBus.tms = tms;

    tap_fsm u_fsm (
        .tck(tck),
        .rst_n(tckRst_n),
        .bus(tapBus)
    );

    // ============================================================
    // level crossings into tck
    always_ff @(posedge tck or negedge tckRst_n) begin
        if (!tckRst_n) begin
            dbgTckS1 <= 1'b0;
            dbgTckS2 <= 1'b0;
            dirtyTckS1 <= 1'b0;
            dirtyTckS2 <= 1'b0;
        end else begin
            dbgTckS1 <= debugActive;
            dbgTckS2 <= dbgTckS1;
            dirtyTckS1 <= commDirty;
            dirtyTckS2 <= dirtyTckS1;
        end
    end

    // ============================================================
    // instruction register
    always_ff @(posedge tck or negedge tckRst_n) begin
        if (!tckRst_n) begin
            irShift <= IR_CAPTURE;
            irLatched <= INS_IDCODE;
            irTog <= 1'b0;
        end else begin
            case (tapBus.state)
                ST_RESET: begin
                    irLatched <= INS_IDCODE;
                    // without a toggle here the clk_sys copy would keep a stale instruction
                    if (irLatched != INS_IDCODE) begin
                        irTog <= ~irTog;
                    end
                end
                ST_CAP_IR: irShift <= IR_CAPTURE;
                ST_SHIFT_IR: irShift <= {tdi, irShift[IR_W-1:1]};
                ST_UPD_IR: begin
                    irLatched <= irShift;
                    irTog <= ~irTog;
                end
                default: irShift <= irShift;
            endcase
        end
    end

    // ============================================================
    // data register selection; debug paths exist only while debug is allowed
    always_comb begin
        drSel = SEL_BYPASS;
        drWidth = BYPASS_W;
        if (irLatched == INS_IDCODE) begin
            drSel = SEL_IDCODE;
            drWidth = IDCODE_W;
        end else if (irLatched == INS_BRKCFG && dbgTckS2) begin
            drSel = SEL_BRKCFG;
            drWidth = BRKCFG_W;
        end else if (irLatched == INS_COMM && dbgTckS2) begin
            drSel = SEL_COMM;
            drWidth = COMM_W;
        end else if (irLatched == INS_INJECT && dbgTckS2) begin
            drSel = SEL_INJECT;
            drWidth = INJECT_W;
        end
    end

    // tdi enters at the top of the selected length, bit 0 leaves first
    always_comb begin
        next_drShift = drShift >> 1;
        next_drShift[drWidth - 7'h01] = tdi;
    end

    // ============================================================
    // data register capture, shift and update
    always_ff @(posedge tck or negedge tckRst_n) begin
        if (!tckRst_n) begin
            drShift <= '0;
        end else if (tapBus.state == ST_CAP_DR) begin
            case (drSel)
                SEL_IDCODE: drShift <= {41'h0, DEVICE_ID};
                SEL_BRKCFG: drShift <= bpCfgTck;
                SEL_COMM: drShift <= {64'h0, dirtyTckS2, commByte};
                default: drShift <= '0;
            endcase
        end else if (tapBus.state == ST_SHIFT_DR) begin
            drShift <= next_drShift;
        end
    end

    // latched outputs of the debug registers move only in update-dr
    always_ff @(posedge tck or negedge tckRst_n) begin
        if (!tckRst_n) begin
            bpCfgTck <= BP_CFG_RESET;
            injWordTck <= 16'h0000;
            bpTog <= 1'b0;
            injTog <= 1'b0;
            clrTog <= 1'b0;
        end else if (tapBus.state == ST_UPD_DR) begin
            case (drSel)
                SEL_BRKCFG: begin
                    bpCfgTck <= drShift;
                    bpTog <= ~bpTog;
                end
                SEL_INJECT: begin
                    injWordTck <= drShift[15:0];
                    injTog <= ~injTog;
                end
                SEL_COMM: clrTog <= ~clrTog;
                default: bpTog <= bpTog;
            endcase
        end
    end

    // ============================================================
    // tdo on the falling edge gives the controller half a period of setup
    always_ff @(negedge tck or negedge tckRst_n) begin
        if (!tckRst_n) begin
            tdo <= 1'b0;
            tdoOe <= 1'b0;
        end else begin
            tdo <= (tapBus.state == ST_SHIFT_IR) ? irShift[0] : drShift[0];
            tdoOe <= (tapBus.state == ST_SHIFT_IR) || (tapBus.state == ST_SHIFT_DR);
        end
    end

    AST_TDO_ONLY_SHIFT: assert property (@(posedge tck) disable iff (!tckRst_n)
        tdoOe |-> (tapBus.state == ST_SHIFT_IR || tapBus.state == ST_SHIFT_DR))
        else $error("tdo driven outside a shift state");
    AST_IR_CAPTURED: assert property (@(posedge tck) disable iff (!tckRst_n)
        tapBus.state == ST_CAP_IR |=> irShift == IR_CAPTURE)
        else $error("capture-ir did not load 0x01");
    AST_IR_UPDATE_ONLY: assert property (@(posedge tck) disable iff (!tckRst_n)
        irLatched != $past(irLatched) |-> ($past(tapBus.state) == ST_UPD_IR || $past(tapBus.state) == ST_RESET))
        else $error("instruction changed outside update-ir");
    AST_RESET_IDCODE: assert property (@(posedge tck) disable iff (!tckRst_n)
        tapBus.state == ST_RESET |=> irLatched == INS_IDCODE)
        else $error("reset state did not select identification");
    AST_BYPASS_ZERO: assert property (@(posedge tck) disable iff (!tckRst_n)
        (tapBus.state == ST_CAP_DR && drSel == SEL_BYPASS) |=> drShift[0] == 1'b0)
        else $error("bypass stage not cleared at capture");
    AST_DR_UPDATE_ONLY: assert property (@(posedge tck) disable iff (!tckRst_n)
        bpCfgTck != $past(bpCfgTck) |-> $past(tapBus.state) == ST_UPD_DR)
        else $error("breakpoint configuration changed outside update-dr");

    // ============================================================
    // clk_sys side: pin synchronisers
    logic [3:0] gateS1;
    logic [3:0] gateS2;
    logic [3:0] togS1;
    logic [3:0] togS2;
    logic [3:0] togS3;
    logic [3:0] togEvent;
    logic [DR_MAX_W-1:0] bpCfg;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            gateS1 <= 4'h0;
            gateS2 <= 4'h0;
            togS1 <= 4'h0;
            togS2 <= 4'h0;
            togS3 <= 4'h0;
        end else begin
            gateS1 <= {lockBitTwo, lockBitOne, debugEnableFuse, testPortEnableFuse};
            gateS2 <= gateS1;
            togS1 <= {clrTog, injTog, bpTog, irTog};
            togS2 <= togS1;
            togS3 <= togS2;
        end
    end

    assign togEvent = togS2 ^ togS3;

    // debug needs both fuses and neither lock bit
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pinsAsPort <= 1'b1;
            debugActive <= 1'b0;
        end else begin
            pinsAsPort <= ~gateS2[0];
            debugActive <= gateS2[0] & gateS2[1] & ~gateS2[2] & ~gateS2[3];
        end
    end

    AST_LOCK_BLOCKS_DEBUG: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (gateS2[2] || gateS2[3] || !gateS2[1]) |=> !debugActive)
        else $error("debug active with a lock bit or missing fuse");

    // ============================================================
    // words from tck: stable in the source register long before their toggle arrives
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            instruction <= INS_IDCODE;
            bpCfg <= BP_CFG_RESET;
            injectValid <= 1'b0;
            injectWord <= 16'h0000;
        end else begin
            injectValid <= togEvent[2] & debugActive;
            if (togEvent[0]) begin
                instruction <= irLatched;
            end
            if (togEvent[1]) begin
                bpCfg <= bpCfgTck;
            end
            if (togEvent[2]) begin
                injectWord <= injWordTck;
            end
        end
    end

    // shared communication byte: cpu write sets dirty, debugger read clears it; a set wins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            commByte <= 8'h00;
            commDirty <= 1'b0;
        end else begin
            if (cpuDataWrite) begin
                commByte <= cpuData;
                commDirty <= 1'b1;
            end else if (togEvent[3]) begin
                commDirty <= 1'b0;
            end
        end
    end

    AST_DIRTY_SET_WINS: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpuDataWrite |=> (commDirty && commByte == $past(cpuData)))
        else $error("cpu write did not mark the byte dirty");

    // ============================================================
    // breakpoint unit
    bp_mode_t bpMode;
    logic rangeMode;
    logic rangeHit;
    logic [BP_COUNT-1:0] bpHit;
    logic [BP_ADDR_W-1:0] bpAddr [BP_COUNT];

    assign bpMode = bp_mode_t'(bpCfg[BP_MODE_LSB +: 3]);
    assign rangeMode = (bpMode == BPM_2PROG_PRANGE) || (bpMode == BPM_2PROG_DRANGE);

    generate
        for (genvar i = 0; i < BP_COUNT; i++) begin : g_bp
            logic isData;
            assign bpAddr[i] = bpCfg[BP_ADDR_LSB + BP_ADDR_W*i +: BP_ADDR_W];
            assign isData = (bpMode == BPM_3PROG_1DATA && i == 3) ||
                (bpMode == BPM_2PROG_2DATA && i >= 2);
            // entries 2 and 3 become address and mask in the range modes
            assign bpHit[i] = bpCfg[BP_EN_LSB + i] && !(rangeMode && i >= 2) &&
                (isData ? (dataValid && dataAddr == bpAddr[i]) : (pcValid && pcAddr == bpAddr[i]));
        end
    endgenerate

    always_comb begin
        rangeHit = 1'b0;
        if (rangeMode && bpCfg[BP_EN_LSB + 2]) begin
            if (bpMode == BPM_2PROG_PRANGE) begin
                rangeHit = pcValid && ((pcAddr & bpAddr[3]) == (bpAddr[2] & bpAddr[3]));
            end else begin
                rangeHit = dataValid && ((dataAddr & bpAddr[3]) == (bpAddr[2] & bpAddr[3]));
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            breakHit <= 1'b0;
        end else begin
            breakHit <= debugActive && ((|bpHit) || rangeHit ||
                (bpCfg[BP_FLOW_BIT] && flowChange) || (bpCfg[BP_STEP_BIT] && stepDone));
        end
    end

    AST_BREAK_NEEDS_DEBUG: assert property (@(posedge clk_sys) disable iff (!reset_n)
        breakHit |-> $past(debugActive))
        else $error("break raised while debug disabled");
    AST_STEP_BREAK: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (debugActive && bpCfg[BP_STEP_BIT] && stepDone) |=> breakHit)
        else $error("single step did not break");
endmodule

// File: src/jtag_pkg.sv
// shared constants and types for the test access port and debug gate
// assumes one clk_sys domain and one tck domain driven by the external test controller
package jtag_pkg;

    // ============================================================
    // controller states
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h2,
        ST_CAP_DR = 4'h3,
        ST_SHIFT_DR = 4'h4,
        ST_EXIT1_DR = 4'h5,
        ST_PAUSE_DR = 4'h6,
        ST_EXIT2_DR = 4'h7,
        ST_UPD_DR = 4'h8,
        ST_SEL_IR = 4'h9,
        ST_CAP_IR = 4'hA,
        ST_SHIFT_IR = 4'hB,
        ST_EXIT1_IR = 4'hC,
        ST_PAUSE_IR = 4'hD,
        ST_EXIT2_IR = 4'hE,
        ST_UPD_IR = 4'hF
    } tap_state_t;

    // ============================================================
    // instruction register
    localparam int IR_W = 4;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] INS_IDCODE = 4'h1;
    localparam logic [3:0] INS_BRKCFG = 4'h5;
    localparam logic [3:0] INS_COMM = 4'h6;
    localparam logic [3:0] INS_INJECT = 4'h7;
    localparam logic [3:0] INS_BYPASS = 4'hF;

    // ============================================================
    // data registers
    typedef enum logic [2:0] {
        SEL_BYPASS = 3'h0,
        SEL_IDCODE = 3'h1,
        SEL_BRKCFG = 3'h2,
        SEL_COMM = 3'h3,
        SEL_INJECT = 3'h4
    } dr_sel_t;

    localparam int DR_MAX_W = 73;
    localparam logic [6:0] BYPASS_W = 7'h01;
    localparam logic [6:0] IDCODE_W = 7'h20;
    localparam logic [6:0] BRKCFG_W = 7'h49;
    localparam logic [6:0] COMM_W = 7'h09;
    localparam logic [6:0] INJECT_W = 7'h10;
    // arbitrary identification value, bit 0 set as the format demands
    localparam logic [31:0] DEVICE_ID = 32'h1234_5001;

    // ============================================================
    // breakpoint configuration layout
    localparam int BP_COUNT = 4;
    localparam int BP_ADDR_W = 16;
    localparam int BP_MODE_LSB = 0;
    localparam int BP_FLOW_BIT = 3;
    localparam int BP_STEP_BIT = 4;
    localparam int BP_EN_LSB = 5;
    localparam int BP_ADDR_LSB = 9;
    localparam logic [72:0] BP_CFG_RESET = 73'h0;

    typedef enum logic [2:0] {
        BPM_4PROG = 3'h0,
        BPM_3PROG_1DATA = 3'h1,
        BPM_2PROG_2DATA = 3'h2,
        BPM_2PROG_PRANGE = 3'h3,
        BPM_2PROG_DRANGE = 3'h4
    } bp_mode_t;

endpackage

// File: src/tap_if.sv
// carries the mode select level and the controller state between the port logic and its state machine
// assumes both ends sit in the tck domain
`timescale 1ns/1ps
interface tap_if;
    import jtag_pkg::*;
    logic tms;
    tap_state_t state;
    modport fsm (input tms, output state);
    modport ctrl (output tms, input state);
endinterface

// File: src/tap_fsm.sv
// sixteen-state test port controller
// assumes rst_n is the power-on reset already gated with the port enable fuse
`timescale 1ns/1ps
module tap_fsm
    import jtag_pkg::*;
(
    input wire logic tck,
    input wire logic rst_n,
    tap_if.fsm bus
);
    tap_state_t next_state;

    // ============================================================
    // state graph
    always_comb begin
        next_state = bus.state;
        case (bus.state)
            ST_RESET: next_state = bus.tms ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = bus.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = bus.tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = bus.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = bus.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = bus.tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = bus.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = bus.tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: next_state = bus.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = bus.tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = bus.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = bus.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = bus.tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = bus.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = bus.tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: next_state = bus.tms ? ST_SEL_DR : ST_IDLE;
            default: next_state = ST_RESET;
        endcase
    end

    // no dedicated test reset pin: only rst_n (power-on reset or a cleared port fuse) or the tms walk returns here
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            bus.state <= ST_RESET;
        end else begin
            bus.state <= next_state;
        end
    end

    // ============================================================
    // checks
    AST_FIVE_HIGH_RESETS: assert property (@(posedge tck) disable iff (!rst_n)
        bus.tms [*5] |=> bus.state == ST_RESET)
        else $error("five tms-high periods did not reach reset");
    AST_IR_PATH: assert property (@(posedge tck) disable iff (!rst_n)
        (bus.tms && bus.state == ST_IDLE) ##1 bus.tms ##1 !bus.tms ##1 !bus.tms
        |=> bus.state == ST_SHIFT_IR)
        else $error("1,1,0,0 from idle missed shift-ir");
    AST_DR_PATH: assert property (@(posedge tck) disable iff (!rst_n)
        (bus.state == ST_IDLE && bus.tms) ##1 !bus.tms ##1 !bus.tms |=> bus.state == ST_SHIFT_DR)
        else $error("1,0,0 from idle missed shift-dr");
    AST_SHIFT_HOLD: assert property (@(posedge tck) disable iff (!rst_n)
        (bus.state == ST_SHIFT_DR && !bus.tms) |=> bus.state == ST_SHIFT_DR)
        else $error("shift-dr left with tms low");
endmodule

// File: sim/jtag_host.sv
// external test controller model: drives tck, tms, tdi and samples tdo
// assumes tdo changes on the tck fall; tck stands low between scans
`timescale 1ns/1ps
module jtag_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // ============================================================
    // single tck period, 160 ns
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // tdo is sampled just before the rise, a full half period after it moved
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #80;
        q = tdo;
        tck = 1'b1;
        #80;
        tck = 1'b0;
    endtask
    // ============================================================
    // five ones always land in reset, then park in idle
    task automatic tlr();
        logic q;
        #1.3;
        repeat (5) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask
    // starts from idle or update; stay leaves it in update for a direct next scan
    task automatic scan(input logic ir, input int w, input logic [72:0] din, input logic stay,
            output logic [72:0] dout);
        logic q;
        dout = '0;
        #1.3;
        step(1'b1, ~tdi, q);
        if (ir) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < w; i++) begin
            step(i == w - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~tdi, q);
        if (!stay) step(1'b0, ~tdi, q);
    endtask
endmodule

// File: sim/tb_top.sv
// self-checking bench for the test port and debug gate
// assumes jtag_host drives the link pins; the design carries its own assertions
`timescale 1ns/1ps
module tb_top
    import jtag_pkg::*;
;
    logic clk_sys, reset_n, tck, tms, tdi, tdo, tdoOe, bitQ;
    logic portFuse, dbgFuse, lockOne, lockTwo, pinsAsPort, debugActive;
    logic cpuDataWrite, commDirty, injectValid, pcValid, flowChange, breakHit;
    logic [3:0] instruction;
    logic [7:0] cpuData, commByte;
    logic [15:0] injectWord, pcAddr, injWord, dataAddr;
    logic dataValid, stepDone;
    logic [72:0] din, dout;
    int seed, n_fail, checks, injSeen;

    jtag_tap_and_debug_gate dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdoOe(tdoOe), .testPortEnableFuse(portFuse), .debugEnableFuse(dbgFuse),
        .lockBitOne(lockOne), .lockBitTwo(lockTwo), .pinsAsPort(pinsAsPort), .debugActive(debugActive),
        .instruction(instruction), .cpuDataWrite(cpuDataWrite), .cpuData(cpuData), .commDirty(commDirty),
        .commByte(commByte), .injectValid(injectValid), .injectWord(injectWord), .pcAddr(pcAddr),
        .pcValid(pcValid), .dataAddr(dataAddr), .dataValid(dataValid), .flowChange(flowChange),
        .stepDone(stepDone), .breakHit(breakHit));
    jtag_host host_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // pulses are short, so they are counted where they happen
    always @(posedge clk_sys) begin
        if (injectValid === 1'b1) begin
            injSeen <= injSeen + 1;
            injWord <= injectWord;
        end
    end
    // ============================================================
    // shared tasks
    task automatic chk(input string what, input logic [72:0] exp, input logic [72:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle();
        repeat (10) @(negedge clk_sys);
    endtask
    task automatic ir(input logic [3:0] code);
        host_u.scan(1'b1, 4, {69'h0, code}, 1'b1, dout);
    endtask
    task automatic dr(input int w, input logic [72:0] d, input logic stay);
        host_u.scan(1'b0, w, d, stay, dout);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        results();
    end
    // ============================================================
    // main sequence
    initial begin
        seed = 42;
        reset_n = 1'b0;
        portFuse = 1'b1;
        dbgFuse = 1'b1;
        lockOne = 1'b0;
        lockTwo = 1'b0;
        cpuDataWrite = 1'b0;
        cpuData = 8'h00;
        pcAddr = 16'h0000;
        pcValid = 1'b0;
        flowChange = 1'b0;
        dataAddr = 16'h0000;
        dataValid = 1'b0;
        stepDone = 1'b0;
        injSeen = 0;
        repeat (4) @(negedge clk_sys);
        reset_n = 1'b1;
        settle();
        chk("instruction", INS_IDCODE, instruction);
        host_u.tlr();
        dr(32, 73'h0, 1'b0);
        chk("idcode", DEVICE_ID, dout[31:0]);
        $display("test idcode done");
        ir(INS_BYPASS);
        chk("irCapture", IR_CAPTURE, dout[3:0]);
        din = $random(seed);
        dr(8, din, 1'b0);
        chk("bypass", {din[6:0], 1'b0}, dout[7:0]);
        chk("tdoOe", 1'b0, tdoOe);
        settle();
        chk("instruction", INS_BYPASS, instruction);
        host_u.step(1'b1, 1'b0, bitQ);
        host_u.step(1'b0, 1'b1, bitQ);
        host_u.tlr();
        dr(32, 73'h0, 1'b0);
        chk("idcodeAfterReset", DEVICE_ID, dout[31:0]);
        settle();
        chk("instructionAfterReset", INS_IDCODE, instruction);
        $display("test ir bypass reset done");
        for (int k = 0; k < 16; k++) begin
            {portFuse, dbgFuse, lockOne, lockTwo} = k[3:0];
            settle();
            chk("debugActive", k == 12, debugActive);
            chk("pinsAsPort", !k[3], pinsAsPort);
        end
        portFuse = 1'b0;
        ir(INS_BYPASS);
        chk("tdoFuseOff", 4'h0, dout[3:0]);
        portFuse = 1'b1;
        lockOne = 1'b0;
        lockTwo = 1'b0;
        settle();
        host_u.tlr();
        $display("test gating done");
        cpuData = $random(seed);
        cpuDataWrite = 1'b1;
        @(negedge clk_sys);
        cpuDataWrite = 1'b0;
        chk("commDirty", 1'b1, commDirty);
        chk("commByte", cpuData, commByte);
        ir(INS_COMM);
        dr(9, 73'h0, 1'b0);
        chk("commScan", {1'b1, cpuData}, dout[8:0]);
        settle();
        chk("commDirtyClear", 1'b0, commDirty);
        $display("test comm done");
        for (int m = 0; m < 5; m++) begin
            din = '0;
            din[2:0] = m[2:0];
            din[BP_FLOW_BIT] = 1'b1;
            din[BP_EN_LSB] = 1'b1;
            din[BP_STEP_BIT] = 1'b1;
            din[BP_EN_LSB + 2] = (m == 2);
            din[BP_ADDR_LSB +: 16] = $random(seed);
            din[BP_ADDR_LSB + 32 +: 16] = $random(seed);
            ir(INS_BRKCFG);
            dr(73, din, 1'b0);
            settle();
            pcAddr = din[BP_ADDR_LSB +: 16];
            pcValid = 1'b1;
            @(negedge clk_sys);
            chk("breakProg", 1'b1, breakHit);
            pcAddr = ~pcAddr;
            @(negedge clk_sys);
            chk("breakMiss", 1'b0, breakHit);
            pcValid = 1'b0;
            flowChange = 1'b1;
            @(negedge clk_sys);
            chk("breakFlow", 1'b1, breakHit);
            flowChange = 1'b0;
            dataAddr = din[BP_ADDR_LSB + 32 +: 16];
            dataValid = 1'b1;
            @(negedge clk_sys);
            chk("breakData", m == 2, breakHit);
            dataValid = 1'b0;
            stepDone = 1'b1;
            @(negedge clk_sys);
            chk("breakStep", 1'b1, breakHit);
            stepDone = 1'b0;
        end
        $display("test breakpoints done");
        for (int p = 0; p < 2; p++) begin
            lockOne = p[0];
            settle();
            injSeen = 0;
            din = $random(seed);
            ir(INS_INJECT);
            dr(16, din, 1'b0);
            settle();
            chk("injectCount", p == 0, injSeen);
            if (p == 0) chk("injectWord", din[15:0], injWord);
        end
        $display("test inject done");
        reset_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        reset_n = 1'b1;
        settle();
        chk("instructionMidReset", INS_IDCODE, instruction);
        chk("commDirtyMidReset", 1'b0, commDirty);
        $display("test mid reset done");
        results();
    end
endmodule
